// ---- rtl/rsotc_top.sv ----
// Switching sequencer, on-time counter, fault gating and APB registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Startup end loads counter with last on-time.
// - Soft-start counter saturates at maximum on-time.
// - Each counted lower period adds the configured step.
// - Divider counts only every Nth lower pulse.
// - Skip-level feedback during soft-start forces maximum.
// - On-time counter up on upper, down lower.
// - Reverse at reference or current-sense end.
// - Enough maximum on-time events enter protection.
// - Reference reloads per cycle from soft-start counter, after soft-start from maximum on-time.
// - Max on-time fault ignored until counter maximum.
// - Ramp code follows the counter bus.
// - Feedback forced low, released along the ramp.
// - Early comparator trip overrides maximum on-time.
// - Soft-start cycle: up to counter, down zero.
// - Repetition off at start, on after trips.
// - Light load inserts controlled off-time between patterns.
// - Quiet skip regulates burst period at clamp.
// - Discharge switch on until bridge node low.
// - Upper switch only with bootstrap supply good.
// - Transition sensor sets the dead-time.
// - Repeat-previous condition ends startup, starts soft-start.
// - Opposite switch on when transition ends.
module rsotc_top #(
  parameter int W              = 12,
  parameter int AUTOREC_CYCLES = rsotc_pkg::AUTOREC_CYCLES
) (
  // Clock and synchronous reset.
  input  wire logic         MCLK,
  input  wire logic         SRST,
  // APB slave.
  input  wire logic         PSEL,
  input  wire logic         PENABLE,
  input  wire logic         PWRITE,
  input  wire logic [7:0]   PADDR,
  input  wire logic [31:0]  PWDATA,
  output logic [31:0]       PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  // Analog comparator and sensor results.
  input  wire logic         FB_SKIP,
  input  wire logic         FB_QUIET,
  input  wire logic         LIGHT_LOAD,
  input  wire logic         CS_STOP,
  input  wire logic         ON_CMP,
  input  wire logic         HB_DONE,
  input  wire logic         BOOT_OK,
  input  wire logic         DVDT_UL,
  input  wire logic         DVDT_LU,
  // Startup sequence result.
  input  wire logic         STARTUP_DONE,
  input  wire logic [W-1:0] STARTUP_TON,
  // Power stage controls.
  output logic              GATE_UP,
  output logic              GATE_LO,
  output logic              DISCHARGE_EN,
  output logic              FB_FORCE_LOW,
  output logic [W-1:0]      SS_DAC,
  output logic              REPEAT_EN,
  output logic              FAULT
);
  rsotc_ss_if #(.W(W)) ss ();

  // Register file.
  logic         en_ff;         // Converter enable.
  logic         latch_ff;      // Latched protection when set, else auto-recovery.
  logic [7:0]   step_ff;       // Soft-start step.
  logic [7:0]   div_ff;        // Soft-start lower-pulse divider.
  logic [W-1:0] max_on_ff;     // Maximum on-time.
  logic [7:0]   lim_ff;        // Maximum on-time events before protection.
  logic [15:0]  dead_max_ff;   // Dead-time clamp in clock cycles.
  logic [15:0]  off_time_ff;   // Light-load off-time.
  logic [15:0]  qs_clamp_ff;   // Quiet skip burst period clamp.
  // Sequencer state.
  rsotc_pkg::rsotc_state_t state_ff, nxt_state;
  logic [W-1:0] oncnt_ff;      // Bidirectional on-time counter.
  logic [W-1:0] ref_ff;        // Maximum on-time comparator reference.
  logic [W-1:0] init_ff;       // Soft-start start value, zero point of the ramp.
  logic [15:0]  timer_ff;      // Dead-time, off-time and recovery timer.
  logic [7:0]   evcnt_ff;      // Maximum on-time event count.
  logic         ss_act_ff;     // Soft-start running.
  logic         rep_ff;        // Previous on-time repetition enabled.
  logic         flt_ff;        // Protection active.
  logic         quiet_ff;      // Quiet skip mode active.
  logic         gate_up_ff, gate_lo_ff, dis_ff, fbl_ff;
  logic [W-1:0] dac_ff;
  logic [31:0]  prdata_ff;
  logic         pready_ff, pslverr_ff;

  // Bus decode.
  wire acc     = PSEL & PENABLE & ~pready_ff;
  wire wr      = PSEL & PENABLE & PWRITE & pready_ff;
  wire hit_ctl = (PADDR == rsotc_pkg::OFS_CTRL);
  wire hit_cfg = (PADDR == rsotc_pkg::OFS_SS_CFG);
  wire hit_max = (PADDR == rsotc_pkg::OFS_MAX_ON);
  wire hit_lim = (PADDR == rsotc_pkg::OFS_FAULT_LIM);
  wire hit_sta = (PADDR == rsotc_pkg::OFS_STATUS);
  wire hit_cnt = (PADDR == rsotc_pkg::OFS_SS_CNT);
  wire hit_dt  = (PADDR == rsotc_pkg::OFS_DEAD_MAX);
  wire hit_off = (PADDR == rsotc_pkg::OFS_OFF_TIME);
  wire hit_qs  = (PADDR == rsotc_pkg::OFS_QS_CLAMP);
  wire mapped  = hit_ctl | hit_cfg | hit_max | hit_lim | hit_sta | hit_cnt | hit_dt |
                 hit_off | hit_qs;
  wire flt_clr = wr & hit_ctl & PWDATA[rsotc_pkg::CTRL_CLR_BIT];

  // Read multiplexer; unmapped reads return zero with an error.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctl)
      rd_mux = {30'h0000_0000, latch_ff, en_ff};
    else if (hit_cfg)
      rd_mux = {16'h0000, div_ff, step_ff};
    else if (hit_max)
      rd_mux = {{(32-W){1'b0}}, max_on_ff};
    else if (hit_lim)
      rd_mux = {24'h00_0000, lim_ff};
    else if (hit_sta)
      rd_mux = {16'h0000, evcnt_ff, ss.at_max, quiet_ff, rep_ff, flt_ff, state_ff};
    else if (hit_cnt)
      rd_mux = {{(32-W){1'b0}}, ss.cnt};
    else if (hit_dt)
      rd_mux = {16'h0000, dead_max_ff};
    else if (hit_off)
      rd_mux = {16'h0000, off_time_ff};
    else if (hit_qs)
      rd_mux = {16'h0000, qs_clamp_ff};
  end

  // One wait state: the answer is prepared in the first access cycle.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~mapped;
      prdata_ff  <= (acc & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // Register writes land at the completing edge only.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      en_ff       <= 1'b0;
      latch_ff    <= 1'b0;
      step_ff     <= rsotc_pkg::RST_SS_STEP;
      div_ff      <= rsotc_pkg::RST_SS_DIV;
      max_on_ff   <= rsotc_pkg::RST_MAX_ON;
      lim_ff      <= rsotc_pkg::RST_FAULT_LIM;
      dead_max_ff <= rsotc_pkg::RST_DEAD_MAX;
      off_time_ff <= rsotc_pkg::RST_OFF_TIME;
      qs_clamp_ff <= rsotc_pkg::RST_QS_CLAMP;
    end
    else if (wr)
    begin
      if (hit_ctl)
      begin
        en_ff    <= PWDATA[rsotc_pkg::CTRL_EN_BIT];
        latch_ff <= PWDATA[rsotc_pkg::CTRL_LATCH_BIT];
      end
      if (hit_cfg)
      begin
        step_ff <= PWDATA[rsotc_pkg::SS_STEP_LSB +: 8];
        div_ff  <= PWDATA[rsotc_pkg::SS_DIV_LSB +: 8];
      end
      if (hit_max)
        max_on_ff <= PWDATA[W-1:0];
      if (hit_lim)
        lim_ff <= PWDATA[7:0];
      if (hit_dt)
        dead_max_ff <= PWDATA[15:0];
      if (hit_off)
        off_time_ff <= PWDATA[15:0];
      if (hit_qs)
        qs_clamp_ff <= PWDATA[15:0];
    end
  end

  // Sequencer decode.
  wire trip     = ~ON_CMP;
  wire at_ref   = (oncnt_ff >= ref_ff);
  wire up_end   = at_ref | CS_STOP | trip;
  // A maximum on-time event counts only once soft-start has reached its end.
  wire max_ev   = (state_ff == rsotc_pkg::ST_UP) & at_ref & ~CS_STOP & ~trip &
                  ~ss_act_ff;
  wire ev_over  = max_ev & ((evcnt_ff + 8'h01) >= lim_ff);
  wire dt_clamp = (timer_ff >= dead_max_ff);
  wire ss_begin = (state_ff == rsotc_pkg::ST_START) & STARTUP_DONE;
  wire skip_req = LIGHT_LOAD | FB_QUIET;
  wire off_done = FB_QUIET ? (timer_ff >= qs_clamp_ff) : (timer_ff >= off_time_ff);
  wire rec_done = latch_ff ? flt_clr : (timer_ff >= AUTOREC_CYCLES[15:0]);
  wire cycle_go = BOOT_OK & (DVDT_LU | dt_clamp);
  // The ramp reads zero until switching runs, so every restart begins from the bottom.
  wire ramp_on  = (ss_act_ff | ss.at_max) & (state_ff > rsotc_pkg::ST_START) &
                  (state_ff != rsotc_pkg::ST_FAULT);

  // Next-state logic of the half-bridge sequence.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      rsotc_pkg::ST_IDLE:
        if (en_ff)
          nxt_state = rsotc_pkg::ST_DISCH;
      rsotc_pkg::ST_DISCH:
        if (HB_DONE)
          nxt_state = rsotc_pkg::ST_START;
      rsotc_pkg::ST_START:
        if (STARTUP_DONE)
          nxt_state = rsotc_pkg::ST_DT_LU;
      rsotc_pkg::ST_UP:
        if (ev_over)
          nxt_state = rsotc_pkg::ST_FAULT;
        else if (up_end)
          nxt_state = rsotc_pkg::ST_DT_UL;
      rsotc_pkg::ST_DT_UL:
        if (DVDT_UL | dt_clamp)
          nxt_state = rsotc_pkg::ST_LO;
      rsotc_pkg::ST_LO:
        if (oncnt_ff == '0)
          nxt_state = (skip_req & ~ss_act_ff) ? rsotc_pkg::ST_OFF
                                              : rsotc_pkg::ST_DT_LU;
      rsotc_pkg::ST_DT_LU:
        if (cycle_go)
          nxt_state = rsotc_pkg::ST_UP;
      rsotc_pkg::ST_OFF:
        if (off_done & BOOT_OK)
          nxt_state = rsotc_pkg::ST_UP;
      rsotc_pkg::ST_FAULT:
        if (rec_done)
          nxt_state = rsotc_pkg::ST_IDLE;
      default:
        nxt_state = rsotc_pkg::ST_IDLE;
    endcase
    // Disabling drops the bridge to idle from any state but protection; restart then passes through discharge.
    if (~en_ff & (state_ff != rsotc_pkg::ST_FAULT))
      nxt_state = rsotc_pkg::ST_IDLE;
  end

  // The counter is asked for a step once per lower conduction period, at its start.
  assign ss.load      = ss_begin;
  assign ss.load_val  = STARTUP_TON;
  assign ss.force_max = ss_act_ff & FB_SKIP;
  assign ss.inc_req   = (nxt_state == rsotc_pkg::ST_LO) &
                        (state_ff != rsotc_pkg::ST_LO);
  assign ss.step      = step_ff;
  assign ss.div       = div_ff;
  assign ss.max_val   = max_on_ff;

  rsotc_sscnt #(.W(W)) u_sscnt (
    .clk (MCLK),
    .rst (SRST),
    .ss  (ss.cntr)
  );

  // State, timer and on-time counter.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      state_ff <= rsotc_pkg::ST_IDLE;
      timer_ff <= 16'h0000;
      oncnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      timer_ff <= (nxt_state != state_ff) ? 16'h0000
                : ((timer_ff == 16'hFFFF) ? timer_ff : timer_ff + 16'h0001);
      if ((nxt_state == rsotc_pkg::ST_FAULT) | (nxt_state == rsotc_pkg::ST_IDLE))
        oncnt_ff <= '0;
      else if ((state_ff == rsotc_pkg::ST_UP) & (nxt_state == rsotc_pkg::ST_UP))
        oncnt_ff <= oncnt_ff + 1'b1;
      else if ((state_ff == rsotc_pkg::ST_LO) & (oncnt_ff != '0))
        oncnt_ff <= oncnt_ff - 1'b1;
    end
  end

  // Soft-start supervision, event counting and protection flags.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ss_act_ff <= 1'b0;
      ref_ff    <= '0;
      init_ff   <= '0;
      evcnt_ff  <= 8'h00;
      rep_ff    <= 1'b0;
      flt_ff    <= 1'b0;
      quiet_ff  <= 1'b0;
    end
    else
    begin
      if (ss_begin)
      begin
        ss_act_ff <= 1'b1;
        init_ff   <= STARTUP_TON;
      end
      else if (ss.at_max | (nxt_state == rsotc_pkg::ST_FAULT) |
               (nxt_state == rsotc_pkg::ST_IDLE))
        ss_act_ff <= 1'b0;
      // Each new upper period latches its own reference.
      if ((nxt_state == rsotc_pkg::ST_UP) & (state_ff != rsotc_pkg::ST_UP))
        ref_ff <= ss_act_ff ? ss.cnt : max_on_ff;
      if (ss_begin | (nxt_state == rsotc_pkg::ST_FAULT))
        evcnt_ff <= 8'h00;
      else if (max_ev & (evcnt_ff != 8'hFF))
        evcnt_ff <= evcnt_ff + 8'h01;
      if (ss_begin)
        rep_ff <= 1'b0;
      else if ((state_ff == rsotc_pkg::ST_UP) & trip)
        rep_ff <= 1'b1;
      // Entering protection wins over a clear written in the same cycle.
      if (nxt_state == rsotc_pkg::ST_FAULT)
        flt_ff <= 1'b1;
      else if (state_ff != rsotc_pkg::ST_FAULT)
        flt_ff <= 1'b0;
      quiet_ff <= FB_QUIET & ~ss_act_ff & (state_ff != rsotc_pkg::ST_IDLE);
    end
  end

  // Output flops; the gate and discharge outputs are decoded from the next state so they align with it.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      gate_up_ff <= 1'b0;
      gate_lo_ff <= 1'b0;
      dis_ff     <= 1'b0;
      fbl_ff     <= 1'b0;
      dac_ff     <= '0;
    end
    else
    begin
      gate_up_ff <= (nxt_state == rsotc_pkg::ST_UP) & BOOT_OK;
      gate_lo_ff <= (nxt_state == rsotc_pkg::ST_LO);
      dis_ff     <= (nxt_state == rsotc_pkg::ST_DISCH);
      // Feedback stays clamped until the loop starts tripping on its own or soft-start ends.
      fbl_ff     <= (ss_act_ff & ~rep_ff) | ss_begin;
      dac_ff     <= ramp_on ? ss.cnt - init_ff : '0;
    end
  end

  assign PRDATA       = prdata_ff;
  assign PREADY       = pready_ff;
  assign PSLVERR      = pslverr_ff;
  assign GATE_UP      = gate_up_ff;
  assign GATE_LO      = gate_lo_ff;
  assign DISCHARGE_EN = dis_ff;
  assign FB_FORCE_LOW = fbl_ff;
  assign SS_DAC       = dac_ff;
  assign REPEAT_EN    = rep_ff;
  assign FAULT        = flt_ff;
endmodule // rsotc_top
`default_nettype wire

// ---- pkg/rsotc_pkg.sv ----
// Shared constants for the resonant soft-start and on-time control block.
package rsotc_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SS_CFG    = 8'h04;
  localparam logic [7:0] OFS_MAX_ON    = 8'h08;
  localparam logic [7:0] OFS_FAULT_LIM = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_SS_CNT    = 8'h14;
  localparam logic [7:0] OFS_DEAD_MAX  = 8'h18;
  localparam logic [7:0] OFS_OFF_TIME  = 8'h1C;
  localparam logic [7:0] OFS_QS_CLAMP  = 8'h20;
  // Control register field positions.
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_CLR_BIT   = 2;
  // Soft-start configuration field positions.
  localparam int SS_STEP_LSB = 0;
  localparam int SS_DIV_LSB  = 8;
  // Reset values of the writable registers.
  localparam logic [11:0] RST_MAX_ON    = 12'h3FF;
  localparam logic [7:0]  RST_SS_STEP   = 8'h04;
  localparam logic [7:0]  RST_SS_DIV    = 8'h00;
  localparam logic [7:0]  RST_FAULT_LIM = 8'h08;
  localparam logic [15:0] RST_DEAD_MAX  = 16'h0032;
  localparam logic [15:0] RST_OFF_TIME  = 16'h0200;
  localparam logic [15:0] RST_QS_CLAMP  = 16'h0800;
  // Auto-recovery wait, given in microseconds at a 100 MHz clock.
  localparam int CLK_MHZ        = 100;
  localparam int AUTOREC_US     = 40;
  localparam int AUTOREC_CYCLES = AUTOREC_US * CLK_MHZ;
  // Operating states of the switching sequencer.
  typedef enum logic [3:0] {
    ST_IDLE, ST_DISCH, ST_START, ST_UP, ST_DT_UL, ST_LO, ST_DT_LU, ST_OFF, ST_FAULT
  } rsotc_state_t;
endpackage

// ---- pkg/rsotc_ss_if.sv ----
// Link between the sequencer and the soft-start counter.
`timescale 1ns/10ps
`default_nettype none
interface rsotc_ss_if #(parameter int W = 12);
  logic         load;      // Load the counter with the start value.
  logic [W-1:0] load_val;  // Last upper on-time of the startup sequence.
  logic         force_max; // End soft-start at once.
  logic         inc_req;   // One pulse per lower-switch conduction period.
  logic [7:0]   step;      // Increment per counted lower pulse.
  logic [7:0]   div;       // Count every div+1 lower pulses.
  logic [W-1:0] max_val;   // Maximum on-time.
  logic [W-1:0] cnt;       // Counter output bus.
  logic         at_max;    // Counter equals the maximum on-time.
  modport ctrl (output load, load_val, force_max, inc_req, step, div, max_val,
                input cnt, at_max);
  modport cntr (input load, load_val, force_max, inc_req, step, div, max_val,
                output cnt, at_max);
endinterface
`default_nettype wire

// ---- rtl/rsotc_sscnt.sv ----
// Unidirectional saturating soft-start counter with lower-pulse divider.
`timescale 1ns/10ps
`default_nettype none
module rsotc_sscnt #(
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic   clk,
  input wire logic   rst,
  // Sequencer side.
  rsotc_ss_if.cntr   ss
);
  logic [W-1:0] cnt_ff;   // Counter state.
  logic [7:0]   div_ff;   // Lower pulses seen since the last increment.
  logic [W:0]   sum;      // Unsaturated next value.
  logic         div_hit;  // This pulse is the counted one.
  logic [W-1:0] nxt_cnt;
  logic [7:0]   nxt_div;

  assign sum     = {1'b0, cnt_ff} + {{(W+1-8){1'b0}}, ss.step};
  assign div_hit = (div_ff >= ss.div);
  assign ss.cnt  = cnt_ff;
  assign ss.at_max = (cnt_ff == ss.max_val);

  // Load wins over forcing, forcing wins over a normal step; the counter goes down only on a load or when the maximum is lowered below it.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    if (ss.load)
    begin
      nxt_cnt = ss.load_val;
      nxt_div = 8'h00;
    end
    else if (ss.force_max)
    begin
      nxt_cnt = ss.max_val;
    end
    else if (ss.inc_req)
    begin
      nxt_div = div_hit ? 8'h00 : div_ff + 8'h01;
      if (div_hit)
      begin
        // Saturate at the maximum on-time, the lowest frequency.
        nxt_cnt = (sum >= {1'b0, ss.max_val}) ? ss.max_val : sum[W-1:0];
      end
    end
  end

  // State update.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      div_ff <= 8'h00;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
    end
  end
endmodule // rsotc_sscnt
`default_nettype wire

// ---- verif/rsotc_stage_model.sv ----
// Half-bridge stage model: node discharge and transition sensors.
`timescale 1ns/10ps
`default_nettype none
module rsotc_stage_model (
  // Clock, reset and sensor delay.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] dly,
  // Gate and discharge controls.
  input  wire logic       gate_up,
  input  wire logic       gate_lo,
  input  wire logic       disch_en,
  // Sensor results.
  output logic            hb_done,
  output logic            dvdt_ul,
  output logic            dvdt_lu
);
  logic [5:0] t_ff;       // Cycles since both gates went off.
  logic [5:0] h_ff;       // Cycles of discharge current.
  logic       last_up_ff; // The upper switch conducted last.
  logic       sensed;     // The node swing has finished.
  // The node takes dly cycles to swing once both gates are off; the sensors report its end.
  always_ff @(posedge clk)
  begin
    t_ff <= (rst || gate_up || gate_lo) ? 6'h00 : t_ff + {5'h00, t_ff != 6'h3F};
    h_ff <= (rst || !disch_en) ? 6'h00 : h_ff + {5'h00, h_ff != 6'h3F};
    last_up_ff <= !rst && (gate_up || (last_up_ff && !gate_lo));
  end
  assign sensed  = t_ff >= {2'h0, dly};
  assign dvdt_ul = sensed && last_up_ff;
  assign dvdt_lu = sensed && !last_up_ff;
  // The node reads low only while the discharge switch pulls it.
  assign hb_done = h_ff >= {2'h0, dly, 2'h0};
endmodule // rsotc_stage_model
`default_nettype wire

// ---- verif/rsotc_chk.sv ----
// Concurrent checks on the top ports of the soft-start block.
`timescale 1ns/10ps
`default_nettype none
module rsotc_chk #(
  parameter int W = 12
) (
  // Clock, reset and bus handshake.
  input wire logic         MCLK,
  input wire logic         SRST,
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PREADY,
  // Sensor inputs.
  input wire logic         BOOT_OK,
  input wire logic         HB_DONE,
  input wire logic         FB_SKIP,
  input wire logic         ON_CMP,
  // Stage controls.
  input wire logic         GATE_UP,
  input wire logic         GATE_LO,
  input wire logic         DISCHARGE_EN,
  input wire logic         FB_FORCE_LOW,
  input wire logic [W-1:0] SS_DAC,
  input wire logic         REPEAT_EN,
  input wire logic         FAULT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // One wait state, then an answer that stands one cycle.
  sequence s_access; PSEL && PENABLE && !PREADY; endsequence
  sequence s_answer; PREADY ##1 !PREADY; endsequence
  a_apb_answer:
    assert property (s_access |=> s_answer) else $error("bus answer out of time");
  a_gates_apart:
    assert property (!(GATE_UP && GATE_LO)) else $error("both gates on");
  a_upper_boot:
    assert property ($rose(GATE_UP) |-> $past(BOOT_OK) || $past(BOOT_OK, 2))
    else $error("upper gate without supply");
  a_disch_quiet:
    assert property (DISCHARGE_EN |-> !GATE_UP && !GATE_LO) else $error("gate in discharge");
  a_disch_ends:
    assert property (DISCHARGE_EN && HB_DONE |-> ##[1:3] !DISCHARGE_EN)
    else $error("discharge kept on");
  a_fault_quiet:
    assert property (FAULT && $past(FAULT) |-> !GATE_UP && !GATE_LO)
    else $error("gate during fault");
  a_reset_clear:
    assert property (disable iff (1'h0) SRST |=> !GATE_UP && !GATE_LO && !FAULT
      && !DISCHARGE_EN && SS_DAC == '0) else $error("output set after reset");
  a_dac_hold:
    assert property (GATE_UP && $past(GATE_UP) && !FB_SKIP && !$past(FB_SKIP)
      |-> $stable(SS_DAC)) else $error("ramp moved in upper period");
  a_dac_start:
    assert property ($rose(FB_FORCE_LOW) |-> SS_DAC == '0) else $error("ramp not at zero");
  a_repeat_trip:
    assert property ($rose(REPEAT_EN) |-> !$past(ON_CMP) || !$past(ON_CMP, 2))
    else $error("repeat on without trip");
endmodule // rsotc_chk
`default_nettype wire

// ---- verif/rsotc_top_tb.sv ----
// Self-checking bench for the soft-start and on-time control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, x) \
  begin \
    check_count++; \
    if ((a) !== (x)) \
    begin \
      $display("mismatch at %0t: got %h expected %h", $time, a, x); \
      errors++; \
    end \
  end
module rsotc_top_tb;
  logic        mclk = 1'h0, srst = 1'h1;              // Clock and reset.
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, hb_done, dvdt_ul, dvdt_lu;
  logic        fb_skip = 1'h0, fb_quiet = 1'h0, light_load = 1'h0, cs_stop = 1'h0;
  logic        on_cmp = 1'h1, boot_ok = 1'h1, startup_done = 1'h1;
  logic [11:0] startup_ton = 12'h008, ss_dac;
  logic        gate_up, gate_lo, disch_en, fb_force_low, repeat_en, fault;
  logic [3:0]  dly = 4'h3;                            // Stage sensor delay.
  int          errors = 0, check_count = 0;
  int          up_w = 0, lo_w = 0, gap_w = 0;
  int          ups[$], los[$], gaps[$];               // Measured widths.
  always #5 mclk = ~mclk;
  rsotc_top #(.W(12), .AUTOREC_CYCLES(20)) i_dut (
    .MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FB_SKIP(fb_skip), .FB_QUIET(fb_quiet), .LIGHT_LOAD(light_load), .CS_STOP(cs_stop),
    .ON_CMP(on_cmp), .HB_DONE(hb_done), .BOOT_OK(boot_ok), .DVDT_UL(dvdt_ul),
    .DVDT_LU(dvdt_lu), .STARTUP_DONE(startup_done), .STARTUP_TON(startup_ton),
    .GATE_UP(gate_up), .GATE_LO(gate_lo), .DISCHARGE_EN(disch_en),
    .FB_FORCE_LOW(fb_force_low), .SS_DAC(ss_dac), .REPEAT_EN(repeat_en), .FAULT(fault));
  rsotc_stage_model i_stage (.clk(mclk), .rst(srst), .dly(dly), .gate_up(gate_up),
    .gate_lo(gate_lo), .disch_en(disch_en), .hb_done(hb_done), .dvdt_ul(dvdt_ul),
    .dvdt_lu(dvdt_lu));
  // Widths are taken on the falling edge, where the registered gates have settled.
  always @(negedge mclk)
  begin
    if (!gate_up && up_w > 0) ups.push_back(up_w);
    if (!gate_lo && lo_w > 0) los.push_back(lo_w);
    if (gate_up && gap_w > 0) gaps.push_back(gap_w);
    up_w = gate_up ? up_w + 1 : 0;
    lo_w = gate_lo ? lo_w + 1 : 0;
    gap_w = (gate_up || gate_lo) ? 0 : gap_w + 1;
  end
  // Bus cycle; the answer is taken at the rising edge where pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  // Waits for n upper pulses under a bound.
  task automatic waitq(input int n);
    int k = 0;
    while (ups.size() < n && k++ < 20000) @(posedge mclk);
    `CHK(ups.size() >= n, 1'h1)
  endtask
  task automatic start(input logic [31:0] cfg);
    wr(rsotc_pkg::OFS_SS_CFG, cfg);
    ups.delete(); los.delete(); gaps.delete();
    wr(rsotc_pkg::OFS_CTRL, 32'h1);
  endtask
  task automatic stop();
    wr(rsotc_pkg::OFS_CTRL, 32'h0);
    repeat (20) @(posedge mclk);
  endtask
  task automatic t_regs();
    rdchk(rsotc_pkg::OFS_SS_CFG, 32'h4, 1'h0);
    rdchk(rsotc_pkg::OFS_MAX_ON, 32'h3FF, 1'h0);
    rdchk(rsotc_pkg::OFS_FAULT_LIM, 32'h8, 1'h0);
    rdchk(rsotc_pkg::OFS_OFF_TIME, 32'h200, 1'h0);
    rdchk(8'h24, 32'h0, 1'h1);
  endtask
  // Plain soft-start with no trip runs into the on-time limit and auto-restarts.
  task automatic t_softstart();
    int k;
    wr(rsotc_pkg::OFS_MAX_ON, 32'h20);
    wr(rsotc_pkg::OFS_FAULT_LIM, 32'h3);
    start(32'h4);
    for (k = 0; k < 300 && disch_en !== 1'h1; k++) @(posedge mclk);
    `CHK(disch_en, 1'h1)
    waitq(2);
    `CHK(fb_force_low, 1'h1)
    waitq(7);
    `CHK(ss_dac, 12'h018)
    for (k = 0; k < 3000 && fault !== 1'h1; k++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    `CHK(ups.size(), 9)
    for (k = 1; k < 9; k++) `CHK(ups[k] - ups[0], (k > 6) ? 24 : 4 * k)
    for (k = 0; k < 8; k++) `CHK(los[k], ups[k])
    for (k = 0; k < 300 && disch_en !== 1'h1; k++) @(posedge mclk);
    `CHK(disch_en, 1'h1)
    `CHK(ss_dac, 12'h000)
    stop();
  endtask
  // Divided increments with slow sensors, then current sense cuts the upper period.
  task automatic t_divider();
    dly <= 4'h9;
    start(32'h104);
    waitq(5);
    `CHK(ups[4] - ups[0], 8)
    cs_stop <= 1'h1;
    waitq(7);
    `CHK(ups[5] < ups[4], 1'h1)
    `CHK(los[5], ups[5])
    cs_stop <= 1'h0;
    dly <= 4'h3;
    stop();
  endtask
  task automatic t_skip();
    int n;
    wr(rsotc_pkg::OFS_FAULT_LIM, 32'h8);
    wr(rsotc_pkg::OFS_OFF_TIME, 32'h40);
    wr(rsotc_pkg::OFS_QS_CLAMP, 32'h60);
    start(32'h4);
    waitq(2);
    fb_skip <= 1'h1;
    waitq(4);
    `CHK(ups[3] - ups[0], 24)
    fb_skip <= 1'h0; on_cmp <= 1'h0;
    waitq(6);
    `CHK(ups[5] < ups[3], 1'h1)
    `CHK(repeat_en, 1'h1)
    light_load <= 1'h1;
    waitq(9);
    `CHK(gaps[8] >= 64, 1'h1)
    fb_quiet <= 1'h1;
    waitq(12);
    `CHK(gaps[11] >= 96, 1'h1)
    boot_ok <= 1'h0;
    n = ups.size();
    repeat (300) @(posedge mclk);
    `CHK(ups.size(), n)
    boot_ok <= 1'h1;
    waitq(n + 1);
    on_cmp <= 1'h1; light_load <= 1'h0; fb_quiet <= 1'h0;
    stop();
  endtask
  // Latched protection must outlast the recovery wait until the clear bit is written.
  task automatic t_latch();
    int k;
    wr(rsotc_pkg::OFS_FAULT_LIM, 32'h1);
    wr(rsotc_pkg::OFS_SS_CFG, 32'h20);
    wr(rsotc_pkg::OFS_CTRL, 32'h3);
    for (k = 0; k < 3000 && fault !== 1'h1; k++) @(posedge mclk);
    repeat (100) @(posedge mclk);
    `CHK(fault, 1'h1)
    wr(rsotc_pkg::OFS_CTRL, 32'h7);
    repeat (2) @(posedge mclk);
    `CHK(fault, 1'h0)
    stop();
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    t_regs();
    t_softstart();
    t_divider();
    t_skip();
    t_latch();
    tally_and_finish();
  end
  // The run needs well under ten thousand cycles; this cuts a hang short.
  initial
  begin
    repeat (90000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end
endmodule // rsotc_top_tb
bind rsotc_top rsotc_chk #(.W(W)) i_chk (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .BOOT_OK(BOOT_OK), .HB_DONE(HB_DONE),
  .FB_SKIP(FB_SKIP), .ON_CMP(ON_CMP), .GATE_UP(GATE_UP), .GATE_LO(GATE_LO),
  .DISCHARGE_EN(DISCHARGE_EN), .FB_FORCE_LOW(FB_FORCE_LOW), .SS_DAC(SS_DAC),
  .REPEAT_EN(REPEAT_EN), .FAULT(FAULT));
`default_nettype wire
